// >>> swlm_lane_mask.sv
// Write port lane masking for a burst-of-two double-rate SRAM.
// Assumes both clock edges arrive as synchronous phase strobes on clock.
`include "swlm_cfg.svh"
module swlm_lane_mask
	import swlm_pkg::*;
(
	// Clocking
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Edge strobes: positive and complementary input clock rises
	input wire logic k_rise,
	input wire logic kn_rise,
	// Write port, read port select and organisation
	input wire logic write_port_select_n,
	input wire logic read_port_select_n,
	input wire swlm_addr_t addr,
	input wire swlm_word_t wdata,
	input wire swlm_sel_t byte_lane_select_n,
	input wire logic [1:0] org,
	// Read port
	input wire swlm_addr_t rd_addr,
	output swlm_word_t rdata,
	output swlm_word_t rdata_oe,
	// Status
	output logic write_busy,
	output logic burst_ready
);
	swlm_state_t st_reg, st_next;
	swlm_beat_t b0_reg, b0_next;
	swlm_addr_t a_reg, a_next;
	swlm_word_t mem [`SWLM_DEPTH];
	swlm_word_t rd_reg;
	swlm_burst_t push_burst, pop_burst;
	logic push, fifo_ready, pop_valid, commit_hi;
	swlm_word_t m0, m1, wm0, wm1;

	// Lane selects mapped per organisation to per-bit enables
	function automatic swlm_word_t lane_mask(swlm_sel_t s, logic [1:0] o);
		swlm_word_t m;
		m = '0;
		unique case (o)
			`SWLM_ORG_X8: begin
				m[`SWLM_NIB_LO:0] = {4{~s[0]}};
				m[`SWLM_NIB_HI:`SWLM_NIB_LO+1] = {4{~s[1]}};
			end
			`SWLM_ORG_X9: m[`SWLM_LANE_W-1:0] = {9{~s[0]}};
			`SWLM_ORG_X18: begin
				m[8:0] = {9{~s[0]}};
				m[17:9] = {9{~s[1]}};
			end
			`SWLM_ORG_X36: begin
				for (int i = 0; i < `SWLM_LANES; i++)
					m[i*`SWLM_LANE_W +: `SWLM_LANE_W] = {9{~s[i]}};
			end
		endcase
		return m;
	endfunction

	// Capture sequence: select sampled on k_rise only
	always_comb begin
		st_next = st_reg;
		b0_next = b0_reg;
		a_next = a_reg;
		push = 1'b0;
		unique case (st_reg)
			SWLM_IDLE: begin
				if (k_rise && !write_port_select_n && fifo_ready) begin
					b0_next = '{data: wdata, sel_n: byte_lane_select_n};
					a_next = addr;
					st_next = SWLM_WAIT_SECOND;
				end
			end
			SWLM_WAIT_SECOND: begin
				// Deselect ignored here, pending burst always finishes
				if (kn_rise) begin
					push = 1'b1;
					st_next = SWLM_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= SWLM_IDLE;
			b0_reg <= '{data: '0, sel_n: `SWLM_SEL_IDLE};
			a_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
			b0_reg <= b0_next;
			a_reg <= a_next;
		end
	end

	// Burst is queued whole, so a half burst never reaches the array
	assign push_burst = '{addr: a_reg, beat0: b0_reg,
		beat1: '{data: wdata, sel_n: byte_lane_select_n}};

	swlm_fifo #(
		.WIDTH($bits(swlm_burst_t)),
		.DEPTH(`SWLM_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_burst),
		.out_valid(pop_valid),
		.out_ready(1'b1),
		.out_data(pop_burst)
	);

	// Array commit: both words of a burst go in on one edge
	assign m0 = lane_mask(pop_burst.beat0.sel_n, org);
	assign m1 = lane_mask(pop_burst.beat1.sel_n, org);
	assign wm0 = (mem[pop_burst.addr] & ~m0) | (pop_burst.beat0.data & m0);
	assign wm1 = (mem[pop_burst.addr + `SWLM_ADDR_W'(1)] & ~m1)
		| (pop_burst.beat1.data & m1);
	assign commit_hi = pop_valid;

	always_ff @(posedge clock) begin
		if (ce && commit_hi) begin
			mem[pop_burst.addr] <= wm0;
			mem[pop_burst.addr + `SWLM_ADDR_W'(1)] <= wm1;
		end
	end

	// Read data registered; drive only while read select is low
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_reg <= '0;
		end else if (ce) begin
			rd_reg <= mem[rd_addr];
		end
	end
	assign rdata = rd_reg;
	assign rdata_oe = (st_reg == SWLM_IDLE && read_port_select_n) ? '0 :
		{`SWLM_WORD_W{!read_port_select_n}};
	assign write_busy = st_reg != SWLM_IDLE;
	assign burst_ready = fifo_ready;

	// Checks
	property p_second_push;
		@(posedge clock) disable iff (rst)
		(ce && st_reg == SWLM_WAIT_SECOND && kn_rise) |-> push;
	endproperty
	a_second_push: assert property (p_second_push) else $error("second word lost");
	property p_start;
		@(posedge clock) disable iff (rst)
		(ce && st_reg == SWLM_IDLE && k_rise && !write_port_select_n && fifo_ready)
		|=> (st_reg == SWLM_WAIT_SECOND && b0_reg.data == $past(wdata));
	endproperty
	a_start: assert property (p_start) else $error("first word not captured");
	property p_no_half;
		@(posedge clock) disable iff (rst) push |-> st_reg == SWLM_WAIT_SECOND;
	endproperty
	a_no_half: assert property (p_no_half) else $error("half burst queued");
	property p_idle_mask;
		@(posedge clock) disable iff (rst)
		(pop_valid && pop_burst.beat0.sel_n == `SWLM_SEL_IDLE) |-> wm0 == mem[pop_burst.addr];
	endproperty
	a_idle_mask: assert property (p_idle_mask) else $error("masked word altered");
	property p_idle_mask1;
		@(posedge clock) disable iff (rst)
		(pop_valid && pop_burst.beat1.sel_n == `SWLM_SEL_IDLE)
		|-> wm1 == mem[pop_burst.addr + `SWLM_ADDR_W'(1)];
	endproperty
	a_idle_mask1: assert property (p_idle_mask1) else $error("masked second word altered");
	// Positive edge alone opens a burst; a complementary rise in idle is ignored
	property p_idle_hold;
		@(posedge clock) disable iff (rst)
		(ce && st_reg == SWLM_IDLE && !k_rise) |=> st_reg == SWLM_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("burst opened without k edge");
	// Only the enabled lanes are compared, untouched lanes may still be unknown
	property p_commit;
		@(posedge clock) disable iff (rst)
		(ce && pop_valid) |=> (mem[$past(pop_burst.addr) + `SWLM_ADDR_W'(1)] & $past(m1))
			== ($past(pop_burst.beat1.data) & $past(m1));
	endproperty
	a_commit: assert property (p_commit) else $error("second word not at next address");
	property p_full36;
		@(posedge clock) disable iff (rst)
		(pop_valid && org == `SWLM_ORG_X36 && pop_burst.beat1.sel_n == '0)
		|-> wm1 == pop_burst.beat1.data;
	endproperty
	a_full36: assert property (p_full36) else $error("full word not stored");
	property p_x8;
		@(posedge clock) disable iff (rst)
		(pop_valid && org == `SWLM_ORG_X8) |-> m0[35:8] == '0 && m0[0] == !pop_burst.beat0.sel_n[0];
	endproperty
	a_x8: assert property (p_x8) else $error("nibble mask wrong");
	property p_x9;
		@(posedge clock) disable iff (rst)
		(pop_valid && org == `SWLM_ORG_X9) |-> m1[35:9] == '0 && m1[8] == !pop_burst.beat1.sel_n[0];
	endproperty
	a_x9: assert property (p_x9) else $error("x9 mask wrong");
	property p_x18;
		@(posedge clock) disable iff (rst)
		(pop_valid && org == `SWLM_ORG_X18) |-> m0[17] == !pop_burst.beat0.sel_n[1];
	endproperty
	a_x18: assert property (p_x18) else $error("x18 mask wrong");
	property p_x36;
		@(posedge clock) disable iff (rst)
		(pop_valid && org == `SWLM_ORG_X36) |-> m0[27] == !pop_burst.beat0.sel_n[3];
	endproperty
	a_x36: assert property (p_x36) else $error("x36 lane 3 wrong");
	c_burst: cover property (@(posedge clock) disable iff (rst) push);
	c_partial: cover property (@(posedge clock) disable iff (rst)
		pop_valid && pop_burst.beat0.sel_n != pop_burst.beat1.sel_n);
	c_full: cover property (@(posedge clock) disable iff (rst) !fifo_ready);
	c_all_off: cover property (@(posedge clock) disable iff (rst) pop_valid
		&& pop_burst.beat0.sel_n == `SWLM_SEL_IDLE && pop_burst.beat1.sel_n == `SWLM_SEL_IDLE);
endmodule // swlm_lane_mask

// >>> swlm_cfg.svh
// Constants for the write-lane mask block: lane layout, depths, reset values.
// Assumes inclusion by the package, the main module and the bench.
`ifndef SWLM_CFG_SVH
`define SWLM_CFG_SVH
`define SWLM_WORD_W 36
`define SWLM_LANES 4
`define SWLM_LANE_W 9
`define SWLM_ADDR_W 4
`define SWLM_DEPTH 16
`define SWLM_FIFO_DEPTH 4
`define SWLM_ORG_X8 2'h0
`define SWLM_ORG_X9 2'h1
`define SWLM_ORG_X18 2'h2
`define SWLM_ORG_X36 2'h3
`define SWLM_NIB_LO 3
`define SWLM_NIB_HI 7
`define SWLM_SEL_IDLE 4'hF
`endif

// >>> swlm_pkg.sv
// Types for the write-lane mask block.
// Assumes swlm_cfg.svh is on the include path.
`include "swlm_cfg.svh"
package swlm_pkg;
	typedef logic [`SWLM_WORD_W-1:0] swlm_word_t;
	typedef logic [`SWLM_LANES-1:0] swlm_sel_t;
	typedef logic [`SWLM_ADDR_W-1:0] swlm_addr_t;
	// One captured beat: data with its own selects
	typedef struct packed {
		swlm_word_t data;
		swlm_sel_t sel_n;
	} swlm_beat_t;
	// A whole burst handed to the array
	typedef struct packed {
		swlm_addr_t addr;
		swlm_beat_t beat0;
		swlm_beat_t beat1;
	} swlm_burst_t;
	typedef enum logic [1:0] {
		SWLM_IDLE,
		SWLM_WAIT_SECOND
	} swlm_state_t;
endpackage

// >>> swlm_fifo.sv
// Small FIFO for whole bursts between capture and the array.
// Assumes a single clock, an async high reset and a common clock enable.
module swlm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clocking
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	// Honest full and empty from the fill count
	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_reg];

	// Pointer and count update
	always_comb begin
		wr_next = push ? wr_reg + AW'(1) : wr_reg;
		rd_next = pop ? rd_reg + AW'(1) : rd_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else if (ce) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage has no reset; read only where count says valid
	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
endmodule // swlm_fifo

// >>> swlm_ctrl_model.sv
// Memory controller model that drives the write port of the lane mask block.
// Assumes the bench calls burst() from its own process on the same clock.
module swlm_ctrl_model
	import swlm_pkg::*;
(
	// Clocking
	input wire logic clock,
	// Write port drive
	output logic k_rise,
	output logic kn_rise,
	output logic write_port_select_n,
	output swlm_addr_t addr,
	output swlm_word_t wdata,
	output swlm_sel_t byte_lane_select_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clocks parked between bursts, no strobes
	initial begin
		k_rise = 1'b0;
		kn_rise = 1'b0;
		write_port_select_n = 1'b1;
		addr = 4'h0;
		wdata = 36'h0;
		byte_lane_select_n = 4'hF;
	end
	// One burst: word 0 on the positive edge, word 1 on the complementary edge
	task automatic burst(input swlm_addr_t a, input swlm_beat_t b0, input swlm_beat_t b1);
		@(posedge clock);
		k_rise <= 1'b1;
		write_port_select_n <= 1'b0;
		addr <= a;
		wdata <= b0.data;
		byte_lane_select_n <= b0.sel_n;
		@(posedge clock);
		k_rise <= 1'b0;
		kn_rise <= 1'b1;
		write_port_select_n <= 1'b1;
		addr <= ~a;
		wdata <= b1.data;
		byte_lane_select_n <= b1.sel_n;
		@(posedge clock);
		// Released lines flip so a stale value never looks held
		kn_rise <= 1'b0;
		wdata <= ~b1.data;
		byte_lane_select_n <= ~b1.sel_n;
	endtask
endmodule // swlm_ctrl_model

// >>> swlm_lane_mask_tb.sv
// Self-checking bench for the lane mask block, all four organisations.
// Assumes the controller model drives the write port; ce is held high.
`include "swlm_cfg.svh"
module swlm_lane_mask_tb
	import swlm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst, ce, k_rise, kn_rise, wps_n, rps_n, write_busy, burst_ready;
	logic [1:0] org;
	swlm_addr_t addr, rd_addr;
	swlm_word_t wdata, rdata, rdata_oe, wm, mem [16];
	swlm_sel_t sel_n;
	logic [31:0] lfsr_state;
	int fails, checks;
	// Clock and time-zero values
	always #50 clock = ~clock;
	initial begin
		clock = 1'b0; rst = 1'b1; ce = 1'b1; rps_n = 1'b1;
		org = `SWLM_ORG_X36; rd_addr = 4'h0; lfsr_state = 32'h6;
	end
	swlm_ctrl_model ctrl (.clock(clock), .k_rise(k_rise), .kn_rise(kn_rise),
		.write_port_select_n(wps_n), .addr(addr), .wdata(wdata), .byte_lane_select_n(sel_n));
	swlm_lane_mask uut (.clock(clock), .rst(rst), .ce(ce), .k_rise(k_rise), .kn_rise(kn_rise),
		.write_port_select_n(wps_n), .read_port_select_n(rps_n), .addr(addr), .wdata(wdata),
		.byte_lane_select_n(sel_n), .org(org), .rd_addr(rd_addr), .rdata(rdata),
		.rdata_oe(rdata_oe), .write_busy(write_busy), .burst_ready(burst_ready));
	// Busy stands from the first word's edge to the second's; FIFO never fills
	always @(negedge clock) begin
		if (k_rise) check({34'h0, write_busy, burst_ready}, 36'h1);
		if (kn_rise) check({35'h0, write_busy}, 36'h1);
	end
	// Random source, fixed start for repeatable runs
	function automatic logic [31:0] rnd();
		lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
		return lfsr_state;
	endfunction
	// Bits that a select pattern lets through, per organisation
	function automatic swlm_word_t lane_mask(input logic [1:0] o, input swlm_sel_t s);
		case (o)
			`SWLM_ORG_X8: return {28'h0, {4{~s[1]}}, {4{~s[0]}}};
			`SWLM_ORG_X9: return {27'h0, {9{~s[0]}}};
			`SWLM_ORG_X18: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
			default: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
		endcase
	endfunction
	task automatic check(input swlm_word_t got, input swlm_word_t exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Reset for two cycles, then look at the idle outputs
	task automatic do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		check(rdata_oe, 36'h0);
		check({35'h0, write_busy}, 36'h0);
		check({35'h0, burst_ready}, 36'h1);
	endtask
	// One burst through the model, mirror updated with each word's own mask
	task automatic wburst(input swlm_addr_t a, input swlm_beat_t b0, input swlm_beat_t b1);
		int n;
		// Ready is looked at mid-cycle, away from the edge that updates it
		@(negedge clock);
		for (n = 0; n < 20 && burst_ready !== 1'b1; n++) @(negedge clock);
		if (n == 20) begin
			fails++;
			summarize();
		end else begin
			ctrl.burst(a, b0, b1);
			mem[a] = (mem[a] & ~lane_mask(org, b0.sel_n)) | (b0.data & lane_mask(org, b0.sel_n));
			a = a + 4'h1;
			mem[a] = (mem[a] & ~lane_mask(org, b1.sel_n)) | (b1.data & lane_mask(org, b1.sel_n));
		end
	endtask
	initial begin
		logic [31:0] r;
		swlm_beat_t b0, b1;
		// Widest organisation first, so every array bit is known before partial writes
		for (int o = 3; o >= 0; o--) begin
			org <= o[1:0];
			do_reset();
			wm = lane_mask(o[1:0], 4'h0);
			// Fill every location with whole words first
			for (int i = 0; i < 8; i++) begin
				r = rnd();
				b0 = '{{r[3:0], rnd()}, 4'h0};
				b1 = '{{r[7:4], rnd()}, 4'h0};
				wburst(4'(i * 2), b0, b1);
			end
			// Random masks; first two are all-off and split-mask corners
			for (int i = 0; i < 24; i++) begin
				r = rnd();
				b0 = '{{r[3:0], rnd()}, (i == 0) ? 4'hF : (i == 1) ? 4'h0 : r[11:8]};
				b1 = '{{r[7:4], rnd()}, (i < 2) ? 4'hF : r[15:12]};
				wburst(r[19:16], b0, b1);
			end
			repeat (4) @(posedge clock);
			rps_n <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				@(posedge clock);
				rd_addr <= 4'(i);
				@(posedge clock);
				@(negedge clock);
				check(rdata & wm, mem[i] & wm);
				check(rdata_oe, {36{1'b1}});
			end
			@(posedge clock);
			rps_n <= 1'b1;
			@(negedge clock);
			check(rdata_oe, 36'h0);
			$display("test org %0d done", o);
			@(posedge clock);
		end
		summarize();
	end
endmodule // swlm_lane_mask_tb
